// ### logic/ffs_dev.sv
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Function
// - Hold eight-bit flag register, status and errors.
// - Read-flags returns all; clear-flags clears errors.
// - Fixed bit map: ready down to reserved.
// - Ready bit is inverse of busy.
// - Host polls ready or busy for completion.
// - Suspend during erase sets erase-suspended.
// - Resume clears erase-suspended bit.
// - Host trusts suspend bits only when ready.
// - Erase failure or protection sets erase error.
// - Erase error sticky until clear-flags.
// - Program failure, or overprogram with accelerator high and pattern a multiple of 64 bits, sets program error.
// - Program error covers all program instructions.
// - Program error sticky until clear-flags.
// - Accelerator drop during operation sets voltage error.
// - Voltage error sticky until clear-flags.
// - Suspend during program sets program-suspended; resume clears it.
// - Protected target or locked write sets protection.
// - Protection error sticky until clear-flags.
// - Modify accepted only on whole-byte clock count.
// - Modify refused unless write-permit latch set.
// - Latch cleared at reset and when a modify instruction is accepted.
// - Driver strength field defaults from nonvolatile.
module ffs_dev
    import ffs_pkg::*;
(
    input  wire logic       sys_clk,         // System clock.
    input  wire logic       rst_n,           // Async reset, active low.
    ffs_if.dev              link,            // Serial link.
    input  wire logic [2:0] nonvolatile_config, // Stored driver strength.
    input  wire logic       op_done,         // Controller finished operation.
    input  wire logic       erase_fail,      // Erase verify failed.
    input  wire logic       prog_fail,       // Program verify failed.
    input  wire logic       over_prog,       // One written over zero.
    input  wire logic       pat64,           // Pattern is multiple of 64 bits.
    input  wire logic       acc_high,        // Accelerator supply at high level.
    input  wire logic       area_prot,       // Target protected or OTP locked.
    input  wire logic       wp_lock,         // Write-protect pin with disable bit.
    output logic            op_start,        // Pulse: program or erase operation begins.
    output logic            op_erase,        // Started operation is an erase.
    output logic [2:0]      volatile_enh_config, // Driver strength field.
    output logic            write_permit_latch,  // Write permit state.
    output logic            busy_flag        // Operation in progress.
);
    // Whole device state.
    typedef struct packed {
        logic [1:0] sck_s;    // Serial clock synchroniser.
        logic [1:0] cs_s;     // Select synchroniser.
        logic [1:0] mo_s;     // Data synchroniser.
        logic       sck_p;    // Previous synced clock.
        logic       cs_p;     // Previous synced select.
        logic [7:0] sh;       // Input shift register.
        logic [2:0] bitc;     // Bit in byte counter.
        logic [3:0] nbyte;    // Bytes received, saturating.
        logic [7:0] op;       // Opcode of frame.
        logic [7:0] tx;       // Output shift register.
        logic       miso;     // Output bit.
        logic [7:0] flags;    // Flag register.
        logic       wpl;      // Write permit latch.
        logic       busy;     // Internal operation active.
        logic       erase;    // Active operation is an erase.
        logic       acc0;     // Accelerator level at start.
        logic [2:0] drv;      // Driver strength.
        logic       drv_ld;   // Driver field loaded after reset.
        logic       start;    // Start pulse.
    } ffs_dev_t;
    ffs_dev_t s_q, s_d;

    // True for instructions that modify data.
    function automatic logic is_mod(input logic [7:0] o);
        is_mod = (o == OP_STATUS_WRITE_CMD) || (o == OP_LOCK_WRITE_CMD) || (o == OP_OTPP) || (o == OP_PPROG) ||
                 (o == OP_DPROG) || (o == OP_DEPROG) || (o == OP_QPROG) ||
                 (o == OP_QEPROG) || (o == OP_SSERA) || (o == OP_SERA) || (o == OP_BERA);
    endfunction : is_mod

    // True for erase instructions.
    function automatic logic is_era(input logic [7:0] o);
        is_era = (o == OP_SSERA) || (o == OP_SERA) || (o == OP_BERA);
    endfunction : is_era

    // Next-state logic for the whole device.
    always_comb begin
        logic rise;
        logic fall;
        logic endf;
        logic [7:0] nsh;
        logic [7:0] fl;
        rise = 1'b0;
        fall = 1'b0;
        endf = 1'b0;
        nsh = 8'h00;
        fl = 8'h00;
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.sck_s = {s_q.sck_s[0], link.sck};
        s_d.cs_s = {s_q.cs_s[0], link.cs_n};
        s_d.mo_s = {s_q.mo_s[0], link.mosi};
        s_d.sck_p = s_q.sck_s[1];
        s_d.cs_p = s_q.cs_s[1];
        rise = s_q.sck_s[1] & ~s_q.sck_p & ~s_q.cs_s[1];
        fall = ~s_q.sck_s[1] & s_q.sck_p & ~s_q.cs_s[1];
        // Only the second select flop is read, so a metastable first stage never leaks.
        endf = s_q.cs_s[1] & ~s_q.cs_p;
        // Flag byte as read: ready is the inverse of busy, reserved bit zero.
        fl = {~s_q.busy, s_q.flags[6:1], 1'b0};
        // A deselected link restarts byte counting for the next frame.
        if (s_q.cs_s[1]) begin
            s_d.bitc = 3'h0;
            s_d.nbyte = 4'h0;
        end
        // Driver field loaded from nonvolatile store once after reset.
        if (!s_q.drv_ld) begin
            s_d.drv = nonvolatile_config;
            s_d.drv_ld = 1'b1;
        end
        // Shift in on rising serial clock.
        if (rise) begin
            nsh = {s_q.sh[6:0], s_q.mo_s[1]};
            s_d.sh = nsh;
            s_d.bitc = s_q.bitc + 3'h1;
            if (s_q.bitc == 3'h7) begin
                if (s_q.nbyte != 4'hf) begin
                    s_d.nbyte = s_q.nbyte + 4'h1;
                end
                if (s_q.nbyte == 4'h0) begin
                    s_d.op = nsh;
                    // Read-flags loads all bits, reserved bit zero.
                    if (nsh == OP_RFLAG) begin
                        s_d.tx = fl;
                    end else if (nsh == OP_RDVEC) begin
                        s_d.tx = {5'h00, s_q.drv};
                    end
                end else if (s_q.nbyte == 4'h1 && s_q.op == OP_WRVEC) begin
                    s_d.drv = nsh[2:0];
                end
            end
        end
        // Shift out on falling serial clock; flags repeat for polling.
        if (fall) begin
            if (s_q.bitc == 3'h0 && s_q.op == OP_RFLAG) begin
                // Fresh flags at each byte start; the first bit goes out now.
                s_d.miso = fl[7];
                s_d.tx = {fl[6:0], 1'b0};
            end else begin
                s_d.miso = s_q.tx[7];
                s_d.tx = {s_q.tx[6:0], 1'b0};
            end
        end
        // Execute instruction at end of frame.
        if (endf && s_q.nbyte != 4'h0) begin
            if (s_q.op == OP_WRITE_ENABLE_CMD) begin
                s_d.wpl = 1'b1;
            end else if (s_q.op == OP_WRITE_DISABLE_CMD) begin
                s_d.wpl = 1'b0;
            end else if (s_q.op == OP_CFLAG) begin
                s_d.flags[FLG_EERR] = 1'b0;
                s_d.flags[FLG_PERR] = 1'b0;
                s_d.flags[FLG_VERR] = 1'b0;
                s_d.flags[FLG_PROT] = 1'b0;
            end else if (s_q.op == OP_SUSP && s_q.busy) begin
                if (s_q.erase) begin
                    s_d.flags[FLG_ESUSP] = 1'b1;
                end else begin
                    s_d.flags[FLG_PSUSP] = 1'b1;
                end
            end else if (s_q.op == OP_RESUME) begin
                s_d.flags[FLG_ESUSP] = 1'b0;
                s_d.flags[FLG_PSUSP] = 1'b0;
            end else if (is_mod(s_q.op) && s_q.bitc == 3'h0 && s_q.wpl && !s_q.busy) begin
                s_d.wpl = 1'b0;
                if (s_q.op == OP_STATUS_WRITE_CMD && wp_lock) begin
                    s_d.flags[FLG_PROT] = 1'b1;
                end else if (area_prot && s_q.op != OP_STATUS_WRITE_CMD) begin
                    s_d.flags[FLG_PROT] = 1'b1;
                    if (is_era(s_q.op)) begin
                        s_d.flags[FLG_EERR] = 1'b1;
                    end else if (s_q.op != OP_LOCK_WRITE_CMD) begin
                        s_d.flags[FLG_PERR] = 1'b1;
                    end
                end else if (s_q.op != OP_STATUS_WRITE_CMD && s_q.op != OP_LOCK_WRITE_CMD) begin
                    s_d.busy = 1'b1;
                    s_d.erase = is_era(s_q.op);
                    s_d.acc0 = acc_high;
                    s_d.start = 1'b1;
                end
            end
        end
        // Events from the controller during an operation; errors are sticky.
        if (s_q.busy) begin
            if (s_q.acc0 && !acc_high) begin
                s_d.flags[FLG_VERR] = 1'b1;
            end
            if (op_done) begin
                s_d.busy = 1'b0;
                if (s_q.erase && erase_fail) begin
                    s_d.flags[FLG_EERR] = 1'b1;
                end
                if (!s_q.erase && (prog_fail || (over_prog && acc_high && pat64))) begin
                    s_d.flags[FLG_PERR] = 1'b1;
                end
            end
        end
        s_d.flags[FLG_READY] = 1'b0;
        s_d.flags[FLG_RSVD] = 1'b0;
    end

    // State register.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.miso = s_q.miso;             // Serial output bit.
    assign op_start = s_q.start;             // Start pulse.
    assign op_erase = s_q.erase;             // Operation kind.
    assign volatile_enh_config = s_q.drv_ld ? s_q.drv : DRV_DEFAULT;
    assign write_permit_latch = s_q.wpl;     // Latch state.
    assign busy_flag = s_q.busy;             // Busy state.
endmodule : ffs_dev

// ### logic/ffs_host.sv
`timescale 1ns/1ps
// APB-driven serial host sending one instruction frame per command.
module ffs_host
    import ffs_pkg::*;
(
    input  wire logic        sys_clk,   // System clock.
    input  wire logic        rst_n,     // Async reset, active low.
    input  wire logic        psel,      // APB select.
    input  wire logic        penable,   // APB enable.
    input  wire logic        pwrite,    // APB write.
    input  wire logic [7:0]  paddr,     // APB address.
    input  wire logic [31:0] pwdata,    // APB write data.
    output logic [31:0]      prdata,    // APB read data.
    output logic             pready,    // APB ready.
    output logic             pslverr,   // APB error.
    ffs_if.host              link       // Serial link.
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_LOW  = 2'b01,
        H_HIGH = 2'b10,
        H_END  = 2'b11
    } ffs_hst_t;
    // Whole host state.
    typedef struct packed {
        ffs_hst_t    st;     // Frame state.
        logic [3:0]  div;    // Half period counter.
        logic [15:0] tx;     // Bits to send, MSB first.
        logic [4:0]  left;   // Remaining bits, 8 or 16.
        logic [7:0]  rx;     // Received byte.
        logic        sck;    // Serial clock out.
        logic        cs_n;   // Select out, active low.
        logic        mosi;   // Data bit out.
        logic [1:0]  mi_s;   // Input synchroniser.
        logic [31:0] rdata;  // Read data.
    } ffs_host_t;
    ffs_host_t h_q, h_d;

    // Register decode and frame sequencing; the serial clock comes from a divider.
    always_comb begin
        logic wr;
        wr = psel & penable & pwrite;
        h_d = h_q;
        h_d.mi_s = {h_q.mi_s[0], link.miso};
        h_d.rdata = 32'h0;
        if (psel && !pwrite) begin
            h_d.rdata = (paddr == REG_STAT) ? {31'h0, h_q.st != H_IDLE} :
                        (paddr == REG_RDAT) ? {24'h0, h_q.rx} : 32'h0;
        end
        case (h_q.st)
            H_IDLE: begin
                // Command word: [15:0] frame, or [7:0] alone when bit 16 is clear; bit 16 selects a two-byte frame.
                if (wr && paddr == REG_CMD) begin
                    h_d.tx = pwdata[16] ? pwdata[15:0] : {pwdata[7:0], 8'h00};
                    h_d.left = pwdata[16] ? 5'h10 : 5'h08;
                    h_d.cs_n = 1'b0;
                    h_d.div = 4'h0;
                    h_d.mosi = pwdata[16] ? pwdata[15] : pwdata[7];
                    h_d.st = H_LOW;
                end
            end
            H_LOW: begin
                h_d.div = h_q.div + 4'h1;
                if (h_q.div == 4'(SCK_HALF - 1)) begin
                    h_d.div = 4'h0;
                    h_d.sck = 1'b1;
                    h_d.rx = {h_q.rx[6:0], h_q.mi_s[1]};
                    h_d.st = H_HIGH;
                end
            end
            H_HIGH: begin
                h_d.div = h_q.div + 4'h1;
                if (h_q.div == 4'(SCK_HALF - 1)) begin
                    h_d.div = 4'h0;
                    h_d.sck = 1'b0;
                    h_d.tx = {h_q.tx[14:0], 1'b0};
                    h_d.mosi = h_q.tx[14];
                    h_d.left = h_q.left - 5'h01;
                    h_d.st = (h_q.left == 5'h01) ? H_END : H_LOW;
                end
            end
            H_END: begin
                h_d.div = h_q.div + 4'h1;
                if (h_q.div == 4'(SCK_HALF - 1)) begin
                    h_d.cs_n = 1'b1;
                    h_d.st = H_IDLE;
                end
            end
            default: h_d.st = H_IDLE;
        endcase
    end

    // State register; the link idles deselected with the clock low.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            h_q <= '{st: H_IDLE, cs_n: 1'b1, default: '0};
        end else begin
            h_q <= h_d;
        end
    end

    assign prdata = h_q.rdata;
    assign pready = psel & penable;
    assign pslverr = 1'b0;
    assign link.sck = h_q.sck;
    assign link.cs_n = h_q.cs_n;
    assign link.mosi = h_q.mosi;
endmodule : ffs_host

// ### logic/ffs_if.sv
`timescale 1ns/1ps
// Serial link between host and flag device.
interface ffs_if;
    logic sck;    // Serial clock from host.
    logic cs_n;   // Chip select, active low.
    logic mosi;   // Host to device data.
    logic miso;   // Device to host data.
    modport dev  (input sck, input cs_n, input mosi, output miso);
    modport host (output sck, output cs_n, output mosi, input miso);
endinterface : ffs_if

// ### logic/ffs_pkg.sv
package ffs_pkg;
    // Flag register bit positions.
    localparam int FLG_READY   = 7;
    localparam int FLG_ESUSP   = 6;
    localparam int FLG_EERR    = 5;
    localparam int FLG_PERR    = 4;
    localparam int FLG_VERR    = 3;
    localparam int FLG_PSUSP   = 2;
    localparam int FLG_PROT    = 1;
    localparam int FLG_RSVD    = 0;
    // Instruction opcodes carried on the link.
    localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE_CMD   = 8'h04;
    localparam logic [7:0] OP_RFLAG  = 8'h70;
    localparam logic [7:0] OP_CFLAG  = 8'h50;
    localparam logic [7:0] OP_SUSP   = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_STATUS_WRITE_CMD   = 8'h01;
    localparam logic [7:0] OP_LOCK_WRITE_CMD   = 8'he5;
    localparam logic [7:0] OP_OTPP   = 8'h42;
    localparam logic [7:0] OP_PPROG  = 8'h02;
    localparam logic [7:0] OP_DPROG  = 8'ha2;
    localparam logic [7:0] OP_DEPROG = 8'hd2;
    localparam logic [7:0] OP_QPROG  = 8'h32;
    localparam logic [7:0] OP_QEPROG = 8'h12;
    localparam logic [7:0] OP_SSERA  = 8'h20;
    localparam logic [7:0] OP_SERA   = 8'hd8;
    localparam logic [7:0] OP_BERA   = 8'hc7;
    localparam logic [7:0] OP_RDVEC  = 8'h65;
    localparam logic [7:0] OP_WRVEC  = 8'h61;
    // Driver strength default, 30 ohm code.
    localparam logic [2:0] DRV_DEFAULT = 3'h7;
    // Host APB register offsets.
    localparam logic [7:0] REG_CMD  = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_RDAT = 8'h08;
    // Serial clock divider half period in system clocks.
    localparam int SCK_HALF = 8;
endpackage : ffs_pkg

// ### test/ffs_props.sv
`timescale 1ns/1ps
// Watches the host-to-device link and the device's operation flow.
module ffs_props (
    input wire logic sys_clk,           // System clock.
    input wire logic rst_n,             // Async reset, active low.
    input wire logic sck,               // Serial clock.
    input wire logic cs_n,              // Chip select, active low.
    input wire logic op_start,          // Operation start pulse.
    input wire logic op_done,           // Operation done pulse.
    input wire logic busy_flag,         // Operation in progress.
    input wire logic write_permit_latch // Write permit state.
);
    logic [7:0] edges_q; // Serial clock rises seen in the current frame.

    // Count serial clock rises while selected, so frame length can be judged.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            edges_q <= 8'h00;
        end else if (cs_n) begin
            edges_q <= 8'h00;
        end else if ($rose(sck)) begin
            edges_q <= edges_q + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_whole_bytes: assert property ($rose(cs_n) |-> edges_q[2:0] == 3'h0)
        else $error("frame ended on a partial byte");
    a_sck_half: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
        else $error("serial clock high phase is not eight cycles");
    a_start_permit: assert property (op_start |-> $past(write_permit_latch))
        else $error("operation started without write permit");
    a_start_frame: assert property (op_start |-> cs_n)
        else $error("operation started inside a frame");
    a_start_idle: assert property (op_start |-> !$past(busy_flag))
        else $error("operation started while busy");
    a_busy_source: assert property ($rose(busy_flag) |-> op_start || $past(op_start))
        else $error("busy rose without a start");
    a_busy_hold: assert property (busy_flag && !op_done && !$past(op_done) |=> busy_flag)
        else $error("busy fell without completion");
    a_busy_ends: assert property (op_done && busy_flag |-> ##[1:3] !busy_flag)
        else $error("busy stayed after completion");
    a_latch_rise: assert property ($rose(write_permit_latch) |-> cs_n)
        else $error("write permit set inside a frame");
    a_latch_cleared: assert property (op_start |-> ##[0:2] !write_permit_latch)
        else $error("write permit kept after a modify");

    c_start: cover property (op_start);
    c_permit: cover property ($rose(write_permit_latch));
    c_done: cover property (op_done && busy_flag);
endmodule : ffs_props

// ### test/test_flash_flag_status_and_write_guard.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
// Host and device joined over the link, plus a raw driver on a second device.
module test_flash_flag_status_and_write_guard;
    import ffs_pkg::*;
    logic        sys_clk = 1'b0;           // System clock.
    logic        rst_n = 1'b0;             // Reset, active low.
    logic        psel, penable, pwrite;    // APB controls.
    logic [7:0]  paddr;                    // APB address.
    logic [31:0] pwdata, prdata;           // APB data.
    logic        pready;                   // APB ready.
    logic [2:0]  nonvolatile_config, volatile_enh_config; // Driver strength.
    logic        op_done, erase_fail, prog_fail, over_prog, pat64; // Controller inputs.
    logic        acc_high, area_prot, wp_lock; // Supply and protection inputs.
    logic        op_start, op_erase, write_permit_latch, busy_flag; // Device outputs.
    logic        latch_2, busy_2;          // Outputs of the raw-driven device.
    int          bad_count, n_compared, cycles; // Bench counters.
    ffs_if lnk();
    ffs_if raw();

    ffs_host i_ffs_host (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr(), .link(lnk));
    ffs_dev i_ffs_dev (.sys_clk, .rst_n, .link(lnk), .nonvolatile_config, .op_done,
        .erase_fail, .prog_fail, .over_prog, .pat64, .acc_high, .area_prot, .wp_lock,
        .op_start, .op_erase, .volatile_enh_config, .write_permit_latch, .busy_flag);
    ffs_dev i_ffs_dev_raw (.sys_clk, .rst_n, .link(raw), .nonvolatile_config, .op_done,
        .erase_fail, .prog_fail, .over_prog, .pat64, .acc_high, .area_prot, .wp_lock,
        .op_start(), .op_erase(), .volatile_enh_config(), .write_permit_latch(latch_2),
        .busy_flag(busy_2));
    ffs_props i_ffs_props (.sys_clk, .rst_n, .sck(lnk.sck), .cs_n(lnk.cs_n), .op_start,
        .op_done, .busy_flag, .write_permit_latch);

    // Free-running system clock.
    always #2.5 sys_clk = ~sys_clk;

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // Cuts a hang short.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 80000) begin
            bad_count++;
            close_out();
        end
    end

    // Expected read-flags byte from the device's state.
    function automatic logic [7:0] fb(logic bz, es, ee, pe, ve, ps, pr);
        return {~bz, es, ee, pe, ve, ps, pr, 1'b0};
    endfunction : fb

    // One APB transfer: setup, then access until ready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // Sends one frame and waits for the host to finish and the device to act.
    task automatic send(input logic [15:0] op, input logic wide = 1'b0);
        logic [31:0] r;
        apb(1'b1, REG_CMD, {15'h0, wide, op}, r);
        do begin
            apb(1'b0, REG_STAT, 32'h0, r);
        end while (r[0] !== 1'b0);
        repeat (4) @(posedge sys_clk);
    endtask : send

    // Reads the flag byte through a two-byte frame and compares it.
    task automatic chk_flags(input logic [7:0] e);
        logic [31:0] r;
        send({OP_RFLAG, 8'h00}, 1'b1);
        apb(1'b0, REG_RDAT, 32'h0, r);
        `CHK("flags", e, r[7:0])
    endtask : chk_flags

    // Completion pulse from the operation controller.
    task automatic done_pulse;
        op_done <= 1'b1;
        @(posedge sys_clk);
        op_done <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : done_pulse

    // Raw frame of n bits, most significant first, data set while clock is low.
    task automatic raw_frame(input logic [15:0] b, input int n);
        raw.cs_n <= 1'b0;
        for (int j = n - 1; j >= 0; j--) begin
            repeat (6) @(posedge sys_clk);
            raw.sck <= 1'b0;
            raw.mosi <= b[j];
            repeat (7) @(posedge sys_clk);
            raw.sck <= 1'b1;
        end
        repeat (6) @(posedge sys_clk);
        raw.sck <= 1'b0;
        repeat (7) @(posedge sys_clk);
        raw.cs_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
    endtask : raw_frame

    // Main sequence.
    initial begin
        logic [7:0] ops [9] = '{OP_PPROG, OP_DPROG, OP_DEPROG, OP_QPROG, OP_QEPROG,
                                OP_OTPP, OP_SSERA, OP_SERA, OP_BERA};
        logic f;
        logic [2:0] dv;
        logic [31:0] r;
        void'($urandom(23436));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {op_done, erase_fail, prog_fail, over_prog, pat64, acc_high, area_prot, wp_lock} = '0;
        nonvolatile_config = 3'($urandom);
        raw.cs_n = 1'b1;
        raw.sck = 1'b0;
        raw.mosi = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `CHK("drive", nonvolatile_config, volatile_enh_config)
        `CHK("latch", 1'b0, write_permit_latch)
        chk_flags(fb(0, 0, 0, 0, 0, 0, 0));
        send({8'h00, OP_PPROG});
        `CHK("busy", 1'b0, busy_flag)
        send({8'h00, OP_WRITE_ENABLE_CMD});
        `CHK("latch", 1'b1, write_permit_latch)
        send({8'h00, OP_WRITE_DISABLE_CMD});
        `CHK("latch", 1'b0, write_permit_latch)
        // Every program and erase instruction, with a random verify failure.
        foreach (ops[i]) begin
            f = 1'($urandom);
            send({8'h00, OP_WRITE_ENABLE_CMD});
            send({8'h00, ops[i]});
            `CHK("busy", 1'b1, busy_flag)
            `CHK("latch", 1'b0, write_permit_latch)
            `CHK("erase", (i > 5), op_erase)
            chk_flags(fb(1, 0, 0, 0, 0, 0, 0));
            erase_fail <= f;
            prog_fail <= f;
            done_pulse();
            chk_flags(fb(0, 0, f && (i > 5), f && (i < 6), 0, 0, 0));
            send({8'h00, OP_WRITE_ENABLE_CMD});
            chk_flags(fb(0, 0, f && (i > 5), f && (i < 6), 0, 0, 0));
            send({8'h00, OP_CFLAG});
            chk_flags(fb(0, 0, 0, 0, 0, 0, 0));
            erase_fail <= 1'b0;
            prog_fail <= 1'b0;
        end
        // Suspend and resume of a program, then of an erase.
        for (int k = 0; k < 2; k++) begin
            send({8'h00, OP_WRITE_ENABLE_CMD});
            send({8'h00, k ? OP_SERA : OP_PPROG});
            send({8'h00, OP_SUSP});
            chk_flags(fb(1, k, 0, 0, 0, !k, 0));
            // The operation may still finish before it enters suspend.
            done_pulse();
            `CHK("busy", 1'b0, busy_flag)
            chk_flags(fb(0, k, 0, 0, 0, !k, 0));
            send({8'h00, OP_RESUME});
            chk_flags(fb(0, 0, 0, 0, 0, 0, 0));
        end
        // Accelerator supply drops during a program.
        acc_high <= 1'b1;
        send({8'h00, OP_WRITE_ENABLE_CMD});
        send({8'h00, OP_QPROG});
        acc_high <= 1'b0;
        done_pulse();
        chk_flags(fb(0, 0, 0, 0, 1, 0, 0));
        send({8'h00, OP_CFLAG});
        // One over zero, with and without the high supply.
        for (int k = 1; k >= 0; k--) begin
            acc_high <= k[0];
            over_prog <= 1'b1;
            pat64 <= 1'b1;
            send({8'h00, OP_WRITE_ENABLE_CMD});
            send({8'h00, OP_PPROG});
            done_pulse();
            chk_flags(fb(0, 0, 0, k[0], 0, 0, 0));
            send({8'h00, OP_CFLAG});
        end
        {acc_high, over_prog, pat64} <= 3'h0;
        // Protected erase and locked status write.
        area_prot <= 1'b1;
        send({8'h00, OP_WRITE_ENABLE_CMD});
        send({8'h00, OP_SSERA});
        `CHK("busy", 1'b0, busy_flag)
        chk_flags(fb(0, 0, 1, 0, 0, 0, 1));
        send({8'h00, OP_CFLAG});
        area_prot <= 1'b0;
        wp_lock <= 1'b1;
        send({8'h00, OP_WRITE_ENABLE_CMD});
        send({8'h00, OP_STATUS_WRITE_CMD});
        chk_flags(fb(0, 0, 0, 0, 0, 0, 1));
        send({8'h00, OP_CFLAG});
        chk_flags(fb(0, 0, 0, 0, 0, 0, 0));
        wp_lock <= 1'b0;
        // Driver strength written and read back over the link.
        dv = 3'($urandom);
        send({OP_WRVEC, 5'h00, dv}, 1'b1);
        send({OP_RDVEC, 8'h00}, 1'b1);
        apb(1'b0, REG_RDAT, 32'h0, r);
        `CHK("drive read", {5'h00, dv}, r[7:0])
        `CHK("drive", dv, volatile_enh_config)
        // Raw link: whole byte accepted, nine-bit program refused.
        raw_frame({8'h00, OP_WRITE_ENABLE_CMD}, 8);
        `CHK("raw latch", 1'b1, latch_2)
        raw_frame({7'h00, OP_PPROG, 1'b0}, 9);
        `CHK("raw busy", 1'b0, busy_2)
        close_out();
    end
endmodule : test_flash_flag_status_and_write_guard
